/* File: rtl/sss_device.sv */
// Device end: senses the status pins and raises exceptions, checkstop and resets.
//
// Behaviour
// [RQ1] Active irq with enable starts exception.
// [RQ2] Irq is level sensed, any arrival time.
// [RQ3] System holds irq until exception taken.
// [RQ4] Pin with both enables starts machine check.
// [RQ5] Pin enabled, check disabled: stop, float outputs.
// [RQ6] Pin enable clear: ignore machine-check pin.
// [RQ7] System holds machine-check pin two cycles.
// [RQ8] Machine-check pin sensed on falling edge.
// [RQ9] Halt request stops device, floats outputs.
// [RQ10] Halt request stays asserted until reset.
// [RQ11] Halt request released after halt status.
// [RQ12] Halt request minimum width per variant.
// [RQ13] Drive halt status on checkstop stop.
// [RQ14] Release halt status on hard reset.
// [RQ15] Hard reset release raises reset exception.
// [RQ16] Float outputs within five clocks of reset.
// [RQ17] System holds hard reset 255 cycles.
// [RQ18] Soft reset falling edge starts exception.
// [RQ19] System holds soft reset two cycles.
// [RQ20] Two-stage synchroniser before any detection.
module sss_device
  import sss_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Status pins
  sss_if.device     link,
  // Enable bits from the machine state and configuration registers
  input  wire logic externalIrqEnable,
  input  wire logic machineCheckEnable,
  input  wire logic machineCheckPinEnable,
  // Exception starts, one-cycle pulses
  output logic      sysMgmtExcStart,
  output logic      machineCheckExcStart,
  output logic      hardResetExcStart,
  output logic      softResetExcStart,
  // Device state
  output logic      checkstopped,
  output logic      outputsEnable
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PIN_COUNT-1:0] syncA;
    logic [PIN_COUNT-1:0] syncB;
    logic [PIN_COUNT-1:0] prevB;
    logic                 inHardReset;
    logic                 halted;
    logic                 smiBusy;
    logic                 outEnable;
    logic                 smiExc;
    logic                 mcExc;
    logic                 hardExc;
    logic                 softExc;
  } sss_dev_state_t;

  localparam sss_dev_state_t DEV_STATE_RESET = '{
    syncA:       PINS_IDLE,
    syncB:       PINS_IDLE,
    prevB:       PINS_IDLE,
    inHardReset: 1'b1,
    halted:      1'b0,
    smiBusy:     1'b0,
    outEnable:   1'b0,
    smiExc:      1'b0,
    mcExc:       1'b0,
    hardExc:     1'b0,
    softExc:     1'b0
  };

  sss_dev_state_t state_reg;
  sss_dev_state_t state_next;

  logic [PIN_COUNT-1:0] pinsRaw;
  logic                 hrstActive;
  logic                 haltActive;
  logic                 smiActive;
  logic                 mcpFell;
  logic                 srstFell;
  logic                 stopNow;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // A falling edge of an active-low pin is its assertion.
  function automatic logic fell(input logic prevLvl, input logic curLvl);
    fell = prevLvl && !curLvl;
  endfunction

  assign pinsRaw[PIN_SMI]  = link.sysMgmtIrqN;
  assign pinsRaw[PIN_MCP]  = link.machineCheckPinN;
  assign pinsRaw[PIN_HALT] = link.haltRequestInN;
  assign pinsRaw[PIN_HRST] = link.hardResetN;
  assign pinsRaw[PIN_SRST] = link.softResetN;

  // Every decision below looks only at the second stage and its delayed copy.
  assign hrstActive = !state_reg.syncB[PIN_HRST];
  assign haltActive = !state_reg.syncB[PIN_HALT];
  // [RQ2] Level sensing
  assign smiActive  = !state_reg.syncB[PIN_SMI];
  // [RQ8] Falling edge detect
  assign mcpFell    = fell(state_reg.prevB[PIN_MCP], state_reg.syncB[PIN_MCP]);
  // [RQ18] Falling edge detect
  assign srstFell   = fell(state_reg.prevB[PIN_SRST], state_reg.syncB[PIN_SRST]);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    stopNow    = 1'b0;
    // [RQ20] Two-stage synchroniser
    state_next.syncA = pinsRaw;
    state_next.syncB = state_reg.syncA;
    state_next.prevB = state_reg.syncB;

    state_next.smiExc  = 1'b0;
    state_next.mcExc   = 1'b0;
    state_next.hardExc = 1'b0;
    state_next.softExc = 1'b0;

    if (hrstActive) begin
      // [RQ14] Release halt status
      state_next.halted      = 1'b0;
      state_next.inHardReset = 1'b1;
      state_next.smiBusy     = 1'b0;
    end else if (state_reg.inHardReset) begin
      // [RQ15] Reset exception on release
      state_next.inHardReset = 1'b0;
      state_next.hardExc     = 1'b1;
    end else if (!state_reg.halted) begin
      // [RQ9] Halt request stops
      if (haltActive) begin
        stopNow = 1'b1;
      end
      // [RQ6] Pin enable gates pin
      if (mcpFell && machineCheckPinEnable) begin
        if (machineCheckEnable) begin
          // [RQ4] Machine check start
          state_next.mcExc = !stopNow;
        end else begin
          // [RQ5] Checkstop on pin
          stopNow = 1'b1;
        end
      end
      state_next.halted = stopNow;

      // [RQ18] Soft reset exception
      state_next.softExc = srstFell && !stopNow;

      // The level stays high until the handler runs, so one start per assertion.
      // [RQ1] Irq exception start
      if (smiActive && externalIrqEnable && !state_reg.smiBusy && !stopNow) begin
        state_next.smiExc  = 1'b1;
        state_next.smiBusy = 1'b1;
      end else if (!smiActive) begin
        // [RQ3] Rearm after release
        state_next.smiBusy = 1'b0;
      end
    end

    // [RQ16] Float outputs on reset
    state_next.outEnable = !hrstActive && !state_next.halted;
  end

  // ---------------------------------------------------------------
  // Register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= DEV_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Open drain: only ever pulls low, the pull-up does the release.
  assign link.haltStatusDrv = 1'b0;
  // [RQ13] Halt status on checkstop
  assign link.haltStatusOe  = state_reg.halted;

  assign sysMgmtExcStart      = state_reg.smiExc;
  assign machineCheckExcStart = state_reg.mcExc;
  assign hardResetExcStart    = state_reg.hardExc;
  assign softResetExcStart    = state_reg.softExc;
  // Gated clocks are modelled by freezing all exception activity in halt.
  assign checkstopped         = state_reg.halted;
  assign outputsEnable        = state_reg.outEnable;

endmodule

/* File: rtl/sss_if.sv */
// Interface carrying the system status pins between system logic and the device.
interface sss_if;

  // ---------------------------------------------------------------
  // Pins, all active low
  // ---------------------------------------------------------------
  logic sysMgmtIrqN;
  logic machineCheckPinN;
  logic haltRequestInN;
  logic hardResetN;
  logic softResetN;
  // Open-drain halt status: drive value, enable and resolved level.
  logic haltStatusDrv;
  logic haltStatusOe;
  logic haltStatusOutN;

  // The external pull-up holds the line high whenever nobody pulls it low.
  assign haltStatusOutN = (haltStatusOe && !haltStatusDrv) ? 1'b0 : 1'b1;

  modport device (
    input  sysMgmtIrqN,
    input  machineCheckPinN,
    input  haltRequestInN,
    input  hardResetN,
    input  softResetN,
    output haltStatusDrv,
    output haltStatusOe
  );

  modport system (
    output sysMgmtIrqN,
    output machineCheckPinN,
    output haltRequestInN,
    output hardResetN,
    output softResetN,
    input  haltStatusOutN
  );

endinterface

/* File: rtl/sss_pkg.sv */
// Shared constants for the system status signal logic.
package sss_pkg;

  // ---------------------------------------------------------------
  // Pin positions inside the sampled pin vector
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 5;
  localparam int PIN_SMI   = 0;
  localparam int PIN_MCP   = 1;
  localparam int PIN_HALT  = 2;
  localparam int PIN_HRST  = 3;
  localparam int PIN_SRST  = 4;

  // All status pins are active low, so the idle level is all ones.
  localparam logic [PIN_COUNT-1:0] PINS_IDLE = 5'h1F;

  // ---------------------------------------------------------------
  // Cycle counts on the bus clock (mclk, 100 MHz)
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Least hard reset width in clock cycles.
  localparam logic [8:0] HRST_MIN_CYCLES = 9'h0FF;
  // Least machine-check pin width in bus cycles.
  localparam logic [1:0] MCP_HOLD_CYCLES = 2'h2;
  // Least soft reset width in bus cycles.
  localparam logic [3:0] SRST_HOLD_CYCLES = 4'h2;
  // Longest delay from hard reset assertion to floated outputs.
  localparam int HRST_FLOAT_MAX_CYCLES = 5;

  // ---------------------------------------------------------------
  // Reset values of the far-end counters
  // ---------------------------------------------------------------
  localparam logic [8:0] HRST_CNT_RESET = HRST_MIN_CYCLES;
  localparam logic [1:0] MCP_CNT_RESET  = 2'h0;
  localparam logic [3:0] SRST_CNT_RESET = 4'h0;

endpackage

/* File: rtl/sss_system.sv */
// System end: drives the status pins with their least widths and holds.
module sss_system
  import sss_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Status pins
  sss_if.system     link,
  // Requests from system control, one-cycle pulses
  input  wire logic smiRequest,
  input  wire logic smiTaken,
  input  wire logic machineCheckRequest,
  input  wire logic haltRequest,
  input  wire logic hardResetRequest,
  input  wire logic softResetRequest,
  // Status
  output logic      hardResetBusy,
  output logic      haltSeen
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [8:0] hrstCnt;
    logic [1:0] mcpCnt;
    logic [3:0] srstCnt;
    logic       smiDrive;
    logic       haltDrive;
    logic       seen;
  } sss_sys_state_t;

  localparam sss_sys_state_t SYS_STATE_RESET = '{
    hrstCnt:   HRST_CNT_RESET,
    mcpCnt:    MCP_CNT_RESET,
    srstCnt:   SRST_CNT_RESET,
    smiDrive:  1'b0,
    haltDrive: 1'b0,
    seen:      1'b0
  };

  sss_sys_state_t state_reg;
  sss_sys_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // The device floats halt status early in hard reset, so the sighting must be
    // remembered until the halt request is released at the end of that reset.
    state_next.seen = state_reg.haltDrive && (state_reg.seen || !link.haltStatusOutN);

    // [RQ3] Hold irq until taken
    if (smiTaken) begin
      state_next.smiDrive = 1'b0;
    end else if (smiRequest) begin
      state_next.smiDrive = 1'b1;
    end

    // [RQ7] Two-cycle machine-check pulse
    if (state_reg.mcpCnt != 2'h0) begin
      state_next.mcpCnt = state_reg.mcpCnt - 2'h1;
    end else if (machineCheckRequest) begin
      state_next.mcpCnt = MCP_HOLD_CYCLES;
    end

    // [RQ19] Soft reset least width
    if (state_reg.srstCnt != 4'h0) begin
      state_next.srstCnt = state_reg.srstCnt - 4'h1;
    end else if (softResetRequest) begin
      state_next.srstCnt = SRST_HOLD_CYCLES;
    end

    // [RQ12] Held far beyond the least width
    if (haltRequest) begin
      state_next.haltDrive = 1'b1;
    end

    // [RQ17] Hard reset least width
    if (state_reg.hrstCnt != 9'h000) begin
      state_next.hrstCnt = state_reg.hrstCnt - 9'h001;
      // [RQ10] Halt held until reset ends
      if (state_reg.hrstCnt == 9'h001) begin
        // [RQ11] Released only once the device halted
        state_next.haltDrive = state_reg.haltDrive && !state_reg.seen;
      end
    end else if (hardResetRequest) begin
      state_next.hrstCnt = HRST_MIN_CYCLES;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= SYS_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  assign link.sysMgmtIrqN      = !state_reg.smiDrive;
  assign link.machineCheckPinN = (state_reg.mcpCnt == 2'h0);
  assign link.haltRequestInN   = !state_reg.haltDrive;
  assign link.hardResetN       = (state_reg.hrstCnt == 9'h000);
  assign link.softResetN       = (state_reg.srstCnt == 4'h0);

  assign hardResetBusy = (state_reg.hrstCnt != 9'h000);
  assign haltSeen      = state_reg.seen;

endmodule

/* File: verification/sss_asserts.sv */
// Concurrent checks on the status pins between the system and device ends.
module sss_asserts
  import sss_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Status pins
  input wire logic sysMgmtIrqN,
  input wire logic machineCheckPinN,
  input wire logic haltRequestInN,
  input wire logic hardResetN,
  input wire logic softResetN,
  input wire logic haltStatusDrv,
  input wire logic haltStatusOe,
  input wire logic haltStatusOutN
);
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------------
  // Helper logic
  // -------------------------------------------------------------
  logic [9:0] lowCnt_reg;
  logic       seenLow_reg;

  // Width of the current hard reset pulse, and whether halt status was seen.
  always_ff @(posedge mclk) begin
    lowCnt_reg  <= (sys_rst || hardResetN) ? 10'h000 : lowCnt_reg + 10'h001;
    seenLow_reg <= !sys_rst && !haltRequestInN && (seenLow_reg || !haltStatusOutN);
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  a_status_on_halt: assert property (
    $fell(haltRequestInN) && hardResetN |-> ##[1:4] (!haltStatusOutN || !hardResetN))
    else $error("halt status not driven after halt request");
  a_open_drain_drive: assert property (haltStatusDrv == 1'b0)
    else $error("halt status driven high");
  a_status_release: assert property (
    $fell(hardResetN) |-> ##[1:5] haltStatusOutN)
    else $error("halt status kept during hard reset");
  a_mcp_two_cycles: assert property (
    $fell(machineCheckPinN) |=> !machineCheckPinN ##1 machineCheckPinN)
    else $error("machine-check pin width not two cycles");
  a_srst_two_cycles: assert property (
    $fell(softResetN) |=> !softResetN ##1 softResetN)
    else $error("soft reset width not two cycles");
  a_hrst_min_width: assert property (
    $rose(hardResetN) |-> lowCnt_reg >= {1'b0, HRST_MIN_CYCLES})
    else $error("hard reset pulse too short");
  a_halt_req_held: assert property (
    !haltRequestInN && hardResetN |=> !haltRequestInN)
    else $error("halt request released before reset");
  a_halt_req_release: assert property (
    $rose(haltRequestInN) |-> seenLow_reg)
    else $error("halt request released before halt status");

  c_halt: cover property ($fell(haltRequestInN));
  c_mcp: cover property ($fell(machineCheckPinN));
  c_hrst_end: cover property ($rose(hardResetN));
endmodule

/* File: verification/system_status_signal_logic_tb.sv */
// Self-checking bench joining the system end and the device end.
module system_status_signal_logic_tb;
  import sss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef enum int {EV_IRQ, EV_MC, EV_HR, EV_SR, EV_STOP} sss_ev_t;

  logic mclk, sys_rst, irqEn, mcEn, mcpEn;
  logic smiReq, smiTaken, mcReq, haltReq, hrstReq, srstReq;
  logic smiExc, mcExc, hrstExc, srstExc, checkstopped, outputsEnable;
  logic hardResetBusy, haltSeen;
  int   num_errors = 0;
  int   num_checks = 0;

  sss_if link ();

  sss_device i_sss_device (.mclk(mclk), .sys_rst(sys_rst), .link(link),
    .externalIrqEnable(irqEn), .machineCheckEnable(mcEn),
    .machineCheckPinEnable(mcpEn), .sysMgmtExcStart(smiExc),
    .machineCheckExcStart(mcExc), .hardResetExcStart(hrstExc),
    .softResetExcStart(srstExc), .checkstopped(checkstopped),
    .outputsEnable(outputsEnable));

  sss_system i_sss_system (.mclk(mclk), .sys_rst(sys_rst), .link(link),
    .smiRequest(smiReq), .smiTaken(smiTaken), .machineCheckRequest(mcReq),
    .haltRequest(haltReq), .hardResetRequest(hrstReq),
    .softResetRequest(srstReq), .hardResetBusy(hardResetBusy), .haltSeen(haltSeen));

  sss_asserts i_sss_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .sysMgmtIrqN(link.sysMgmtIrqN), .machineCheckPinN(link.machineCheckPinN),
    .haltRequestInN(link.haltRequestInN), .hardResetN(link.hardResetN),
    .softResetN(link.softResetN), .haltStatusDrv(link.haltStatusDrv),
    .haltStatusOe(link.haltStatusOe), .haltStatusOutN(link.haltStatusOutN));

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  function automatic logic sig(input sss_ev_t s);
    case (s)
      EV_IRQ: sig = smiExc;
      EV_MC: sig = mcExc;
      EV_HR: sig = hrstExc;
      EV_SR: sig = srstExc;
      default: sig = checkstopped;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulses are one cycle wide, so every cycle of the window is looked at.
  task automatic expect_ev(input sss_ev_t s, input logic want, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      if (sig(s) === 1'b1) seen = 1'b1;
    end
    chk({7'h00, seen}, {7'h00, want});
  endtask

  task automatic pulse(ref logic r);
    @(negedge mclk);
    r = 1'b1;
    @(negedge mclk);
    r = 1'b0;
  endtask

  task automatic wait_reset_end();
    repeat (300) if (hardResetBusy !== 1'b0) @(negedge mclk);
    expect_ev(EV_HR, 1'b1, 8);
    chk({7'h00, outputsEnable}, 8'h01);
  endtask

  task automatic hard_reset();
    pulse(hrstReq);
    repeat (HRST_FLOAT_MAX_CYCLES + 1) @(negedge mclk);
    chk({7'h00, outputsEnable}, 8'h00);
    chk({7'h00, link.haltStatusOutN}, 8'h01);
    wait_reset_end();
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_irq();
    irqEn = 1'b0;
    pulse(smiReq);
    expect_ev(EV_IRQ, 1'b0, 8);
    irqEn = 1'b1;
    expect_ev(EV_IRQ, 1'b1, 4);
    expect_ev(EV_IRQ, 1'b0, 8);
    pulse(smiTaken);
    $display("done: irq");
  endtask

  task automatic t_mcheck();
    for (int i = 0; i < 3; i++) begin
      mcpEn = (i != 0);
      mcEn = (i == 1);
      pulse(mcReq);
      expect_ev(EV_MC, i == 1, 8);
      chk({7'h00, checkstopped}, {7'h00, i == 2});
    end
    chk({7'h00, link.haltStatusOutN}, 8'h00);
    chk({7'h00, outputsEnable}, 8'h00);
    pulse(srstReq);
    expect_ev(EV_SR, 1'b0, 8);
    hard_reset();
    $display("done: machine check");
  endtask

  task automatic t_halt();
    pulse(srstReq);
    expect_ev(EV_SR, 1'b1, 8);
    pulse(haltReq);
    expect_ev(EV_STOP, 1'b1, 8);
    chk({7'h00, link.haltStatusOutN}, 8'h00);
    chk({7'h00, outputsEnable}, 8'h00);
    chk({7'h00, haltSeen}, 8'h01);
    hard_reset();
    chk({7'h00, link.haltRequestInN}, 8'h01);
    chk({7'h00, checkstopped}, 8'h00);
    chk({7'h00, haltSeen}, 8'h00);
    $display("done: halt and soft reset");
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {mclk, irqEn, mcEn, mcpEn, smiReq, smiTaken} = 6'h00;
    {mcReq, haltReq, hrstReq, srstReq} = 4'h0;
    sys_rst = 1'b1;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    wait_reset_end();
    $display("done: power on");
    t_irq();
    t_mcheck();
    t_halt();
    give_verdict();
  end

  // The scenarios need under 2000 cycles; this bound leaves wide margin.
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
endmodule
